// *** src/hsgts_sequencer.sv ***
// Purpose: gate and timer current-source sequencer of a hot swap controller
// Assumes: sys_rst_i is the undervoltage lockout and supply-wake reset
// Notes: comparator inputs are asynchronous and pass two flops first
//
// Function
// - gate pull-down forced before internal logic wakes, via reset state.
// - in reset enable strong gate pull-down and large timer sink.
// - gate held low during initial cycle; no charge until on high.
// - initial cycle starts with small timer pull-up until low threshold.
// - then large timer pull-down until low comparator trips; cycle ends.
// - after initial cycle start hot swap if on, else wait for on.
// - hot swap start enables only gate charge-pump pull-up.
// - current at fault-timing threshold enables fault timer pull-up.
// - current drops before timeout: large timer sink, gate fully on.
// - timer high trips with current above threshold: fault, gate sink.
// - gate sink stays after fault until retry; on low-high forces retry.
// - fast trip comparator enables gate pull-down sink immediately.
// - auto-retry: weak timer sink after fault, restart at low threshold.
// - adc mux selects current or voltage; conversions start on command.
// - results returned in two or three bytes after all conversions.
// - device is a serial-bus slave only, master limited to fast mode.
// - on low aborts with gate and timer pull-downs; rising edge starts.
// - on input glitch-filtered, shorter level changes ignored.
// - latch-off: stay off after fault until on cycles low then high.

`timescale 1ns/1ns

module hsgts_sequencer #(
  parameter logic AUTO_RETRY = 1'b1,
  parameter int unsigned ON_FILTER_CYCLES = hsgts_pkg::ON_FILTER_CYCLES,
  parameter int unsigned ADC_CONV_CYCLES = hsgts_pkg::ADC_CONV_CYCLES
) (
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic on_cmp_i,
  input wire logic timer_high_cmp_i,
  input wire logic timer_low_cmp_i,
  input wire logic fault_timing_cmp_i,
  input wire logic fast_trip_cmp_i,
  input wire logic conv_volt_req_i,
  input wire logic conv_curr_req_i,
  input wire logic [hsgts_pkg::ADC_W-1:0] adc_data_i,
  output logic gate_pullup_en_o,
  output logic gate_full_on_o,
  output logic gate_strong_pulldown_en_o,
  output logic gate_fault_pulldown_en_o,
  output logic timer_init_pullup_en_o,
  output logic timer_fault_pullup_en_o,
  output logic timer_large_pulldown_en_o,
  output logic timer_weak_pulldown_en_o,
  output logic fault_o,
  output logic adc_mux_sel_o,
  output logic adc_start_o,
  output logic [hsgts_pkg::ADC_W-1:0] volt_result_o,
  output logic [hsgts_pkg::ADC_W-1:0] curr_result_o,
  output logic results_ready_o,
  output logic [1:0] read_bytes_o
);
  // -------------------------------------------------------------------
  // input synchronisers
  // -------------------------------------------------------------------
  localparam int unsigned NCMP = 5;
  logic [NCMP-1:0] cmp_raw;
  logic [NCMP-1:0] cmp_meta;
  logic [NCMP-1:0] cmp_sync;

  assign cmp_raw = {on_cmp_i, timer_high_cmp_i, timer_low_cmp_i,
                    fault_timing_cmp_i, fast_trip_cmp_i};

  genvar gi;
  generate
    for (gi = 0; gi < NCMP; gi++) begin : g_sync
      // no reset here: a reset value below the idle level of a pin would
      // fake a comparator edge on release, e.g. timer low ending the ramp
      always_ff @(posedge mclk_i) begin
        cmp_meta[gi] <= cmp_raw[gi];
        cmp_sync[gi] <= cmp_meta[gi];
      end
    end
  endgenerate

  logic on_raw_s;
  logic timer_high;
  logic timer_low;
  logic over_fault;
  logic fast_trip;
  assign on_raw_s = cmp_sync[4];
  assign timer_high = cmp_sync[3];
  assign timer_low = cmp_sync[2];
  assign over_fault = cmp_sync[1];
  assign fast_trip = cmp_sync[0];

  // -------------------------------------------------------------------
  // on glitch filter
  // -------------------------------------------------------------------
  // a new level must hold for the whole interval before it is accepted
  logic on_filt;
  logic on_filt_d;
  logic [hsgts_pkg::ON_FILTER_W-1:0] on_cnt;

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      on_filt <= 1'b0;
      on_cnt <= hsgts_pkg::ON_FILTER_RESET;
    end else if (on_raw_s == on_filt) begin
      on_cnt <= hsgts_pkg::ON_FILTER_RESET;
    end else if (on_cnt >= hsgts_pkg::ON_FILTER_W'(ON_FILTER_CYCLES - 1)) begin
      on_filt <= on_raw_s;
      on_cnt <= hsgts_pkg::ON_FILTER_RESET;
    end else begin
      on_cnt <= on_cnt + 10'h001;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      on_filt_d <= 1'b0;
    end else begin
      on_filt_d <= on_filt;
    end
  end

  logic on_rise;
  assign on_rise = on_filt && !on_filt_d;

  // -------------------------------------------------------------------
  // sequencer
  // -------------------------------------------------------------------
  hsgts_pkg::hsgts_state_type state;
  hsgts_pkg::hsgts_state_type next_state;
  logic init_done;

  // the initial cycle runs once per reset; on low never repeats it
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      init_done <= 1'b0;
    end else if (state == hsgts_pkg::HSGTS_INIT_DOWN && timer_low) begin
      init_done <= 1'b1;
    end
  end

  always_comb begin
    next_state = state;
    case (state)
      hsgts_pkg::HSGTS_RESET: begin
        next_state = hsgts_pkg::HSGTS_INIT_UP;
      end
      hsgts_pkg::HSGTS_INIT_UP: begin
        // timer ramps up until it passes the low threshold
        if (!timer_low) begin
          next_state = hsgts_pkg::HSGTS_INIT_DOWN;
        end
      end
      hsgts_pkg::HSGTS_INIT_DOWN: begin
        if (timer_low) begin
          next_state = on_filt ? hsgts_pkg::HSGTS_CHARGE
                               : hsgts_pkg::HSGTS_WAIT_ON;
        end
      end
      hsgts_pkg::HSGTS_WAIT_ON: begin
        if (on_filt) begin
          next_state = hsgts_pkg::HSGTS_CHARGE;
        end
      end
      hsgts_pkg::HSGTS_CHARGE: begin
        if (!on_filt) begin
          next_state = hsgts_pkg::HSGTS_OFF;
        end else if (over_fault) begin
          next_state = hsgts_pkg::HSGTS_FAULT_TIME;
        end
      end
      hsgts_pkg::HSGTS_FAULT_TIME: begin
        if (!on_filt) begin
          next_state = hsgts_pkg::HSGTS_OFF;
        end else if (!over_fault) begin
          next_state = hsgts_pkg::HSGTS_FULL_ON;
        end else if (timer_high) begin
          next_state = AUTO_RETRY ? hsgts_pkg::HSGTS_COOLDOWN
                                  : hsgts_pkg::HSGTS_LATCHED;
        end
      end
      hsgts_pkg::HSGTS_FULL_ON: begin
        if (!on_filt) begin
          next_state = hsgts_pkg::HSGTS_OFF;
        end else if (over_fault) begin
          next_state = hsgts_pkg::HSGTS_FAULT_TIME;
        end
      end
      hsgts_pkg::HSGTS_COOLDOWN: begin
        if (!on_filt) begin
          next_state = hsgts_pkg::HSGTS_OFF;
        end else if (timer_low) begin
          next_state = hsgts_pkg::HSGTS_CHARGE;
        end
      end
      hsgts_pkg::HSGTS_LATCHED: begin
        if (!on_filt) begin
          next_state = hsgts_pkg::HSGTS_OFF;
        end
      end
      hsgts_pkg::HSGTS_OFF: begin
        if (on_rise) begin
          next_state = init_done ? hsgts_pkg::HSGTS_CHARGE
                                 : hsgts_pkg::HSGTS_WAIT_ON;
        end
      end
      default: begin
        next_state = hsgts_pkg::HSGTS_RESET;
      end
    endcase
    // on high before the initial cycle ends only matters once it is done
    if (!init_done && (state == hsgts_pkg::HSGTS_WAIT_ON)) begin
      next_state = state;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      state <= hsgts_pkg::HSGTS_RESET;
    end else begin
      state <= next_state;
    end
  end

  // -------------------------------------------------------------------
  // current source enables
  // -------------------------------------------------------------------
  // decoded from next_state so each enable is a flop yet tracks the state
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      gate_strong_pulldown_en_o <= 1'b1;
      timer_large_pulldown_en_o <= 1'b1;
      gate_pullup_en_o <= 1'b0;
      gate_full_on_o <= 1'b0;
      gate_fault_pulldown_en_o <= 1'b0;
      timer_init_pullup_en_o <= 1'b0;
      timer_fault_pullup_en_o <= 1'b0;
      timer_weak_pulldown_en_o <= 1'b0;
      fault_o <= 1'b0;
    end else begin
      gate_strong_pulldown_en_o <= (next_state == hsgts_pkg::HSGTS_RESET);
      gate_pullup_en_o <= !fast_trip &&
        (next_state == hsgts_pkg::HSGTS_CHARGE ||
         next_state == hsgts_pkg::HSGTS_FAULT_TIME ||
         next_state == hsgts_pkg::HSGTS_FULL_ON);
      gate_full_on_o <= !fast_trip && (next_state == hsgts_pkg::HSGTS_FULL_ON);
      // sink covers fault states, on-low abort, and any fast trip
      gate_fault_pulldown_en_o <= fast_trip ||
        next_state == hsgts_pkg::HSGTS_LATCHED ||
        next_state == hsgts_pkg::HSGTS_COOLDOWN ||
        next_state == hsgts_pkg::HSGTS_OFF ||
        next_state == hsgts_pkg::HSGTS_INIT_UP ||
        next_state == hsgts_pkg::HSGTS_INIT_DOWN ||
        next_state == hsgts_pkg::HSGTS_WAIT_ON;
      timer_init_pullup_en_o <= (next_state == hsgts_pkg::HSGTS_INIT_UP);
      timer_fault_pullup_en_o <= (next_state == hsgts_pkg::HSGTS_FAULT_TIME);
      // left off while charging: only the gate source runs then
      timer_large_pulldown_en_o <= next_state == hsgts_pkg::HSGTS_RESET ||
        next_state == hsgts_pkg::HSGTS_INIT_DOWN ||
        next_state == hsgts_pkg::HSGTS_FULL_ON ||
        next_state == hsgts_pkg::HSGTS_WAIT_ON ||
        next_state == hsgts_pkg::HSGTS_LATCHED ||
        next_state == hsgts_pkg::HSGTS_OFF;
      timer_weak_pulldown_en_o <= (next_state == hsgts_pkg::HSGTS_COOLDOWN);
      fault_o <= next_state == hsgts_pkg::HSGTS_LATCHED ||
        next_state == hsgts_pkg::HSGTS_COOLDOWN;
    end
  end

  // -------------------------------------------------------------------
  // readback
  // -------------------------------------------------------------------
  // the serial-bus slave itself sits outside; it hands over requests
  hsgts_adc_ctrl #(
    .CONV_CYCLES(ADC_CONV_CYCLES)
  ) u_adc (
    .mclk_i(mclk_i),
    .sys_rst_i(sys_rst_i),
    .conv_volt_req_i(conv_volt_req_i),
    .conv_curr_req_i(conv_curr_req_i),
    .adc_data_i(adc_data_i),
    .adc_mux_sel_o(adc_mux_sel_o),
    .adc_start_o(adc_start_o),
    .volt_result_o(volt_result_o),
    .curr_result_o(curr_result_o),
    .results_ready_o(results_ready_o),
    .read_bytes_o(read_bytes_o)
  );
endmodule : hsgts_sequencer

// *** src/hsgts_pkg.sv ***
// Purpose: shared constants for the hot swap gate and timer sequencer
// Assumes: comparator results arrive as pins and are synchronised inside
// Notes: on filter count derived from a 250 MHz clock

package hsgts_pkg;
  // -------------------------------------------------------------------
  // clock and timing
  // -------------------------------------------------------------------
  localparam int unsigned CLK_MHZ = 250;
  localparam int unsigned ON_FILTER_US = 3;
  localparam int unsigned ON_FILTER_CYCLES = ON_FILTER_US * CLK_MHZ;
  localparam int unsigned ON_FILTER_W = 10;
  localparam logic [ON_FILTER_W-1:0] ON_FILTER_RESET = 10'h000;

  // -------------------------------------------------------------------
  // adc readback
  // -------------------------------------------------------------------
  localparam int unsigned ADC_W = 12;
  localparam int unsigned ADC_CONV_CYCLES = 64;
  localparam logic [6:0] ADC_CNT_RESET = 7'h00;
  localparam logic [ADC_W-1:0] ADC_RESULT_RESET = 12'h000;
  localparam logic MUX_SEL_CURRENT = 1'b0;
  localparam logic MUX_SEL_VOLTAGE = 1'b1;

  // -------------------------------------------------------------------
  // sequencer states
  // -------------------------------------------------------------------
  typedef enum logic [3:0] {
    HSGTS_RESET = 4'h0,
    HSGTS_INIT_UP = 4'h1,
    HSGTS_INIT_DOWN = 4'h2,
    HSGTS_WAIT_ON = 4'h3,
    HSGTS_CHARGE = 4'h4,
    HSGTS_FAULT_TIME = 4'h5,
    HSGTS_FULL_ON = 4'h6,
    HSGTS_LATCHED = 4'h7,
    HSGTS_COOLDOWN = 4'h8,
    HSGTS_OFF = 4'h9
  } hsgts_state_type;
endpackage : hsgts_pkg

// *** src/hsgts_adc_ctrl.sv ***
// Purpose: adc mux and conversion sequencing for voltage and current readback
// Assumes: requests come from the serial-bus slave logic on the same clock
// Notes: conversion time is a plain parameter, the converter is external

`timescale 1ns/1ns

module hsgts_adc_ctrl #(
  parameter int unsigned CONV_CYCLES = hsgts_pkg::ADC_CONV_CYCLES
) (
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic conv_volt_req_i,
  input wire logic conv_curr_req_i,
  input wire logic [hsgts_pkg::ADC_W-1:0] adc_data_i,
  output logic adc_mux_sel_o,
  output logic adc_start_o,
  output logic [hsgts_pkg::ADC_W-1:0] volt_result_o,
  output logic [hsgts_pkg::ADC_W-1:0] curr_result_o,
  output logic results_ready_o,
  output logic [1:0] read_bytes_o
);
  logic pend_volt;
  logic pend_curr;
  logic busy;
  logic [6:0] cnt;
  logic two_chan;

  // -------------------------------------------------------------------
  // conversion control
  // -------------------------------------------------------------------
  // a new request during a conversion is queued, never lost
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      pend_volt <= 1'b0;
      pend_curr <= 1'b0;
      busy <= 1'b0;
      cnt <= hsgts_pkg::ADC_CNT_RESET;
      adc_mux_sel_o <= hsgts_pkg::MUX_SEL_CURRENT;
      adc_start_o <= 1'b0;
      volt_result_o <= hsgts_pkg::ADC_RESULT_RESET;
      curr_result_o <= hsgts_pkg::ADC_RESULT_RESET;
      results_ready_o <= 1'b0;
      read_bytes_o <= 2'h2;
      two_chan <= 1'b0;
    end else begin
      adc_start_o <= 1'b0;
      if (!busy) begin
        if (pend_curr || conv_curr_req_i) begin
          two_chan <= pend_volt || conv_volt_req_i;
          pend_volt <= pend_volt || conv_volt_req_i;
          pend_curr <= 1'b0;
          adc_mux_sel_o <= hsgts_pkg::MUX_SEL_CURRENT;
          adc_start_o <= 1'b1;
          busy <= 1'b1;
          results_ready_o <= 1'b0;
          cnt <= 7'(CONV_CYCLES - 1);
        end else if (pend_volt || conv_volt_req_i) begin
          pend_volt <= 1'b0;
          adc_mux_sel_o <= hsgts_pkg::MUX_SEL_VOLTAGE;
          adc_start_o <= 1'b1;
          busy <= 1'b1;
          if (!two_chan) begin
            results_ready_o <= 1'b0;
          end
          cnt <= 7'(CONV_CYCLES - 1);
        end
      end else begin
        pend_volt <= pend_volt || conv_volt_req_i;
        pend_curr <= pend_curr || conv_curr_req_i;
        if (cnt == hsgts_pkg::ADC_CNT_RESET) begin
          busy <= 1'b0;
          if (adc_mux_sel_o == hsgts_pkg::MUX_SEL_CURRENT) begin
            curr_result_o <= adc_data_i;
          end else begin
            volt_result_o <= adc_data_i;
          end
          // results stand only when every requested channel is done
          if (!pend_volt || adc_mux_sel_o == hsgts_pkg::MUX_SEL_VOLTAGE) begin
            results_ready_o <= !pend_curr && !conv_curr_req_i;
            read_bytes_o <= two_chan ? 2'h3 : 2'h2;
            two_chan <= 1'b0;
          end
        end else begin
          cnt <= cnt - 7'h01;
        end
      end
    end
  end
endmodule : hsgts_adc_ctrl

// *** test/hsgts_props.sv ***
// Purpose: port checks for the hot swap gate and timer sequencer
// Assumes: comparator pins pass two sync flops before use
// Notes: delays match the designed latency; only the on-low check leaves two cycles of slack
`timescale 1ns/1ns
module hsgts_props #(
  parameter logic AUTO_RETRY = 1'b1,
  parameter int unsigned ON_FILTER_CYCLES = 4
) (
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic on_cmp_i,
  input wire logic fault_timing_cmp_i,
  input wire logic fast_trip_cmp_i,
  input wire logic gate_pullup_en_o,
  input wire logic gate_full_on_o,
  input wire logic gate_strong_pulldown_en_o,
  input wire logic gate_fault_pulldown_en_o,
  input wire logic timer_init_pullup_en_o,
  input wire logic timer_fault_pullup_en_o,
  input wire logic timer_large_pulldown_en_o,
  input wire logic timer_weak_pulldown_en_o,
  input wire logic fault_o
);
  // -----------------------------------------------------------------
  // cycles on has been low, saturating so long runs stay quiet
  // -----------------------------------------------------------------
  logic [11:0] on_low_cnt;
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i || on_cmp_i) begin
      on_low_cnt <= 12'h000;
    end else if (on_low_cnt != 12'hfff) begin
      on_low_cnt <= on_low_cnt + 12'h001;
    end
  end
  default clocking @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);
  property p_rst_hold;
    $fell(sys_rst_i) |-> gate_strong_pulldown_en_o && timer_large_pulldown_en_o
      && !gate_pullup_en_o;
  endproperty
  a_rst_hold: assert property (p_rst_hold) else $error("reset pull-downs missing");
  property p_init_up;
    timer_init_pullup_en_o |-> gate_fault_pulldown_en_o && !gate_pullup_en_o
      && !timer_large_pulldown_en_o;
  endproperty
  a_init_up: assert property (p_init_up) else $error("init charge wrong");
  property p_init_down;
    $fell(timer_init_pullup_en_o) |-> timer_large_pulldown_en_o && !gate_pullup_en_o;
  endproperty
  a_init_down: assert property (p_init_down) else $error("init discharge wrong");
  property p_charge_only;
    gate_pullup_en_o |-> !gate_fault_pulldown_en_o && !gate_strong_pulldown_en_o
      && !timer_init_pullup_en_o && !fault_o;
  endproperty
  a_charge_only: assert property (p_charge_only) else $error("gate charge conflict");
  property p_fault_time;
    $rose(timer_fault_pullup_en_o) |-> $past(fault_timing_cmp_i, 3);
  endproperty
  a_fault_time: assert property (p_fault_time) else $error("fault timer no cause");
  property p_full_on;
    gate_full_on_o |-> timer_large_pulldown_en_o && !timer_fault_pullup_en_o;
  endproperty
  a_full_on: assert property (p_full_on) else $error("full on timer wrong");
  property p_fault_hold;
    fault_o |-> gate_fault_pulldown_en_o && !gate_pullup_en_o && !gate_full_on_o;
  endproperty
  a_fault_hold: assert property (p_fault_hold) else $error("gate not sunk in fault");
  property p_cooldown;
    fault_o && AUTO_RETRY |-> timer_weak_pulldown_en_o && !timer_fault_pullup_en_o;
  endproperty
  a_cooldown: assert property (p_cooldown) else $error("cooldown sink missing");
  property p_fast_trip;
    fast_trip_cmp_i [*4] |-> gate_fault_pulldown_en_o && !gate_pullup_en_o;
  endproperty
  a_fast_trip: assert property (p_fast_trip) else $error("fast trip ignored");
  property p_on_low;
    int'(on_low_cnt) > ON_FILTER_CYCLES + 4 |-> !gate_pullup_en_o && !gate_full_on_o;
  endproperty
  a_on_low: assert property (p_on_low) else $error("gate on while on low");
endmodule : hsgts_props

bind hsgts_sequencer hsgts_props #(
  .AUTO_RETRY(AUTO_RETRY),
  .ON_FILTER_CYCLES(ON_FILTER_CYCLES)
) u_props (.mclk_i, .sys_rst_i, .on_cmp_i, .fault_timing_cmp_i, .fast_trip_cmp_i,
  .gate_pullup_en_o, .gate_full_on_o, .gate_strong_pulldown_en_o, .gate_fault_pulldown_en_o,
  .timer_init_pullup_en_o, .timer_fault_pullup_en_o, .timer_large_pulldown_en_o,
  .timer_weak_pulldown_en_o, .fault_o);

// *** test/hsgts_far_side.sv ***
// Purpose: timer capacitor and its two comparators
// Assumes: one step per clock stands for the charge of each source
// Notes: levels scaled down so fault and cooldown fit a short run
`timescale 1ns/1ns
module hsgts_far_side #(
  parameter int HIGH_LVL = 260,
  parameter int LOW_LVL = 40
) (
  input wire logic mclk_i,
  input wire logic init_up_i,
  input wire logic fault_up_i,
  input wire logic large_dn_i,
  input wire logic weak_dn_i,
  output logic timer_high_cmp_o,
  output logic timer_low_cmp_o
);
  int lvl = 0;
  int nxt;
  // step ratios keep fault timing far shorter than cooldown
  always_comb begin
    nxt = lvl + int'(init_up_i) + 12 * int'(fault_up_i) - 20 * int'(large_dn_i)
      - int'(weak_dn_i);
  end
  always @(posedge mclk_i) begin
    lvl <= (nxt < 0) ? 0 : nxt;
  end
  assign timer_high_cmp_o = (lvl >= HIGH_LVL);
  assign timer_low_cmp_o = (lvl <= LOW_LVL);
endmodule : hsgts_far_side

// *** test/testbench.sv ***
// Purpose: self-checking bench for the gate and timer sequencer
// Assumes: auto-retry and latch-off builds, short on filter and conversion counts
// Notes: adc results are scored from a queue by a watcher process
`timescale 1ns/1ns
module testbench;
  logic mclk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic on_cmp_i = 1'b0;
  logic fault_timing_cmp_i = 1'b0;
  logic fast_trip_cmp_i = 1'b0;
  logic conv_volt_req_i = 1'b0;
  logic conv_curr_req_i = 1'b0;
  logic [hsgts_pkg::ADC_W-1:0] adc_data_i = 12'h000;
  logic [hsgts_pkg::ADC_W-1:0] vres, cres;
  logic th, tl, gpu, gfo, gsp, gfp, tip, tfp, tlp, twp, flt, rdy;
  logic rdy_q = 1'b0;
  logic [1:0] nbytes;
  logic [8:0] vec;
  logic [27:0] exp_q[$];
  int n_fail = 0;
  int num_checks = 0;
  int seed = 32'h489e;
  assign vec = {gpu, gfo, gsp, gfp, tip, tfp, tlp, twp, flt};
  always #2 mclk_i = ~mclk_i;
  hsgts_sequencer #(.AUTO_RETRY(1'b1), .ON_FILTER_CYCLES(4), .ADC_CONV_CYCLES(4)) DUT (
    .mclk_i, .sys_rst_i, .on_cmp_i, .timer_high_cmp_i(th), .timer_low_cmp_i(tl),
    .fault_timing_cmp_i, .fast_trip_cmp_i, .conv_volt_req_i, .conv_curr_req_i, .adc_data_i,
    .gate_pullup_en_o(gpu), .gate_full_on_o(gfo), .gate_strong_pulldown_en_o(gsp),
    .gate_fault_pulldown_en_o(gfp), .timer_init_pullup_en_o(tip),
    .timer_fault_pullup_en_o(tfp), .timer_large_pulldown_en_o(tlp),
    .timer_weak_pulldown_en_o(twp), .fault_o(flt), .adc_mux_sel_o(), .adc_start_o(),
    .volt_result_o(vres), .curr_result_o(cres), .results_ready_o(rdy), .read_bytes_o(nbytes));
  hsgts_far_side u_far (.mclk_i, .init_up_i(tip), .fault_up_i(tfp), .large_dn_i(tlp),
    .weak_dn_i(twp), .timer_high_cmp_o(th), .timer_low_cmp_o(tl));
  wire [8:0] vec2;
  logic th2, tl2;
  // latch-off build on the same stimulus, with its own timer capacitor
  hsgts_sequencer #(.AUTO_RETRY(1'b0), .ON_FILTER_CYCLES(4), .ADC_CONV_CYCLES(4)) u_latch (
    .mclk_i, .sys_rst_i, .on_cmp_i, .timer_high_cmp_i(th2), .timer_low_cmp_i(tl2),
    .fault_timing_cmp_i, .fast_trip_cmp_i, .conv_volt_req_i, .conv_curr_req_i, .adc_data_i,
    .gate_pullup_en_o(vec2[8]), .gate_full_on_o(vec2[7]), .gate_strong_pulldown_en_o(vec2[6]),
    .gate_fault_pulldown_en_o(vec2[5]), .timer_init_pullup_en_o(vec2[4]),
    .timer_fault_pullup_en_o(vec2[3]), .timer_large_pulldown_en_o(vec2[2]),
    .timer_weak_pulldown_en_o(vec2[1]), .fault_o(vec2[0]), .adc_mux_sel_o(), .adc_start_o(),
    .volt_result_o(), .curr_result_o(), .results_ready_o(), .read_bytes_o());
  hsgts_far_side u_far2 (.mclk_i, .init_up_i(vec2[4]), .fault_up_i(vec2[3]),
    .large_dn_i(vec2[2]), .weak_dn_i(vec2[1]), .timer_high_cmp_o(th2), .timer_low_cmp_o(tl2));
  // -------------------------------------------------------------------
  // shared tasks
  // -------------------------------------------------------------------
  task automatic check(input logic [25:0] seen, input logic [25:0] want);
    num_checks++;
    if (seen !== want) begin
      n_fail++;
      $display("FAIL time=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask : check
  task automatic report_and_stop();
    $display("checks=%0d mismatches=%0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : report_and_stop
  task automatic tick(input int n);
    repeat (n) @(posedge mclk_i);
  endtask : tick
  // polls at the falling edge, where registered outputs have settled
  task automatic wait_vec(input bit adc, input logic [8:0] mask, input logic [8:0] want,
      input int lim);
    int i;
    i = 0;
    while ((adc ? (rdy !== 1'b1) : ((vec & mask) !== want)) && i < lim) begin
      @(negedge mclk_i);
      i++;
    end
    if (i >= lim) begin
      n_fail++;
      report_and_stop();
    end
    if (!adc) begin
      check(vec & mask, want);
    end
  endtask : wait_vec
  task automatic adc_req(input logic cv, input logic cc);
    logic [hsgts_pkg::ADC_W-1:0] d;
    d = 12'($random(seed));
    exp_q.push_back({cv, cc, (cv && cc) ? 2'h3 : 2'h2, cv ? d : 12'h000, cc ? d : 12'h000});
    @(posedge mclk_i);
    adc_data_i <= d;
    conv_volt_req_i <= cv;
    conv_curr_req_i <= cc;
    tick(1);
    conv_volt_req_i <= 1'b0;
    conv_curr_req_i <= 1'b0;
    repeat (2) @(negedge mclk_i);
    wait_vec(1'b1, 9'h000, 9'h000, 60);
    tick(2);
  endtask : adc_req
  always @(posedge mclk_i) begin
    logic [27:0] e;
    rdy_q <= rdy;
    if (rdy === 1'b1 && rdy_q !== 1'b1) begin
      e = exp_q.pop_front();
      check({nbytes, e[27] ? vres : 12'h000, e[26] ? cres : 12'h000}, e[25:0]);
    end
  end
  initial begin
    int k;
    tick(12);
    check(vec, 9'h044);
    sys_rst_i <= 1'b0;
    wait_vec(1'b0, 9'h1ff, 9'h030, 10);
    wait_vec(1'b0, 9'h114, 9'h004, 80);
    repeat (40) @(negedge mclk_i);
    check(vec & 9'h180, 9'h000);
    tick(1);
    on_cmp_i <= 1'b1;
    wait_vec(1'b0, 9'h1ff, 9'h100, 30);
    tick(1);
    fault_timing_cmp_i <= 1'b1;
    wait_vec(1'b0, 9'h00d, 9'h008, 10);
    tick(2 + ($unsigned($random(seed)) % 4));
    fault_timing_cmp_i <= 1'b0;
    wait_vec(1'b0, 9'h08d, 9'h084, 10);
    tick(1);
    fast_trip_cmp_i <= 1'b1;
    wait_vec(1'b0, 9'h120, 9'h020, 10);
    tick(3);
    fast_trip_cmp_i <= 1'b0;
    wait_vec(1'b0, 9'h1a4, 9'h184, 10);
    tick(1);
    on_cmp_i <= 1'b0;
    wait_vec(1'b0, 9'h1a4, 9'h024, 20);
    tick(1);
    on_cmp_i <= 1'b1;
    tick(1 + ($unsigned($random(seed)) % 3));
    on_cmp_i <= 1'b0;
    repeat (20) @(negedge mclk_i);
    check(vec & 9'h180, 9'h000);
    tick(1);
    on_cmp_i <= 1'b1;
    wait_vec(1'b0, 9'h1ff, 9'h100, 30);
    for (k = 0; k < 2; k++) begin
      tick(1);
      fault_timing_cmp_i <= 1'b1;
      wait_vec(1'b0, 9'h123, 9'h023, 60);
      tick(1);
      fault_timing_cmp_i <= 1'b0;
      if (k == 1) begin
        on_cmp_i <= 1'b0;
        tick(12);
        check(vec & 9'h120, 9'h020);
        on_cmp_i <= 1'b1;
      end
      // a forced retry must beat the long cooldown by far
      wait_vec(1'b0, 9'h1ff, 9'h100, (k == 0) ? 400 : 40);
      check(vec2 & 9'h1a3, (k == 0) ? 9'h021 : 9'h100);
    end
    for (k = 1; k < 4; k++) begin
      adc_req(k[1], k[0]);
    end
    tick(1);
    sys_rst_i <= 1'b1;
    tick(3);
    check(vec, 9'h044);
    sys_rst_i <= 1'b0;
    wait_vec(1'b0, 9'h1ff, 9'h030, 10);
    check(26'(exp_q.size()), 26'h0);
    report_and_stop();
  end
endmodule : testbench
